/* File: hdl/dihc_issue_control.sv */
// Issue and hazard control for a two-sided VLIW core: predicates, cross-path
// stalls, result latency scheduling and packet checks.
// Assumes the dispatcher holds a packet while pk_ready is low.
// How it works
// - Single-cycle results readable next cycle
// - Two-cycle results readable two cycles later
// - Four-cycle results written at i plus three
// - Every unit accepts a new instruction each cycle
// - Load base update at i, data at i+4
// - Store zero, multiply one, branch five slots
// - Cycle i is the first execute phase
// - Top opcode bits select condition register, zero-test
// - Side-A register zero also predicates
// - Zero-test bit picks zero or nonzero test
// - At most one operand via cross path
// - Address units may cross for arithmetic only
// - Cross select reads opposite destination file
// - Cross read of last-cycle update stalls once
// - Load data destinations never cause cross stalls
// - Address path reaches both address units
// - Each transfer resource pairs address and data paths
// - Non-aligned word accesses need no alignment
`timescale 1ns/1ns
module dihc_issue_control (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Execute packet from dispatch
  input wire logic pk_valid,
  input wire dihc_pkg::dihc_slot_type pk [dihc_pkg::NSLOT],
  input wire logic [dihc_pkg::NCOND-1:0] cond_nonzero,
  output logic pk_ready,
  // Issue status in the first execute phase
  output logic stall,
  output logic [dihc_pkg::NSLOT-1:0] exec_mask,
  output dihc_pkg::dihc_event_type base_upd [dihc_pkg::NSLOT],
  output dihc_pkg::dihc_route_type mem_route [dihc_pkg::NSLOT],
  output logic bkpt_hit,
  output logic cond_rsv,
  output dihc_pkg::dihc_error_type pk_error,
  // Later effects
  output logic branch_take,
  output dihc_pkg::dihc_event_type wb [dihc_pkg::NSLOT][dihc_pkg::NLANE]
);

  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_PARK = 1'b1
  } dihc_issue_state_type;

  dihc_issue_state_type state;
  dihc_pkg::dihc_slot_type parked [dihc_pkg::NSLOT];
  dihc_pkg::dihc_slot_type cand [dihc_pkg::NSLOT];
  dihc_pkg::dihc_event_type ev [dihc_pkg::NSLOT];
  dihc_pkg::dihc_class_type cls [dihc_pkg::NSLOT];
  dihc_pkg::dihc_error_type next_error;
  logic [dihc_pkg::NSLOT-1:0] pass;
  logic [dihc_pkg::NSLOT-1:0] bk;
  logic [dihc_pkg::NSLOT-1:0] rs;
  logic [63:0] wmask;
  logic [3:0] nmem;
  logic cand_v;
  logic hazard;
  logic fire;
  logic br_now;
  logic [dihc_pkg::BR_TAKE-1:0] br_pipe;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Side of a slot: the upper half of the slots sits on side B.
  function automatic logic side_of(input int s);
    side_of = (s >= int'(dihc_pkg::SLOTS_PER_SIDE));
  endfunction

  // Predicate: field is the condition selector followed by the zero test.
  // With the test bit clear the instruction runs on nonzero, set on zero.
  function automatic logic cond_pass(input logic [3:0] f,
                                     input logic [5:0] nz);
    logic t;
    t = f[0];
    unique case (f[3:1])
      dihc_pkg::CREG_NONE: cond_pass = ~t;
      dihc_pkg::CREG_B0: cond_pass = t ^ nz[dihc_pkg::IDX_B0];
      dihc_pkg::CREG_B1: cond_pass = t ^ nz[dihc_pkg::IDX_B1];
      dihc_pkg::CREG_B2: cond_pass = t ^ nz[dihc_pkg::IDX_B2];
      dihc_pkg::CREG_A1: cond_pass = t ^ nz[dihc_pkg::IDX_A1];
      dihc_pkg::CREG_A2: cond_pass = t ^ nz[dihc_pkg::IDX_A2];
      dihc_pkg::CREG_A0: cond_pass = t ^ nz[dihc_pkg::IDX_A0];
      dihc_pkg::CREG_RSV: cond_pass = 1'b0;
    endcase
  endfunction

  // A class writes a result register unless it is a nop, store or branch.
  function automatic logic writes(input dihc_pkg::dihc_class_type c);
    writes = !(c inside {dihc_pkg::CLS_NOP, dihc_pkg::CLS_STORE,
                         dihc_pkg::CLS_BRANCH});
  endfunction

  // ==========================================================================
  // Candidate packet
  // ==========================================================================
  // A parked packet has priority; the port is closed while one waits.
  assign cand_v = (state == ST_PARK) || (pk_valid && pk_ready);
  assign fire = cand_v && !hazard;

  // Select the packet that tries to enter the first execute phase.
  always_comb begin
    for (int s = 0; s < int'(dihc_pkg::NSLOT); s++) begin
      cand[s] = (state == ST_PARK) ? parked[s] : pk[s];
    end
  end

  // Decode predicates, breakpoint and reserved selector codes.
  always_comb begin
    for (int s = 0; s < int'(dihc_pkg::NSLOT); s++) begin
      pass[s] = cand[s].valid &&
        cond_pass(cand[s].opword[dihc_pkg::CREG_HI:dihc_pkg::ZBIT],
                  cond_nonzero);
      bk[s] = cand[s].valid && cand[s].opword[dihc_pkg::ZBIT] &&
        (cand[s].opword[dihc_pkg::CREG_HI-:3] == dihc_pkg::CREG_NONE);
      rs[s] = cand[s].valid &&
        (cand[s].opword[dihc_pkg::CREG_HI-:3] == dihc_pkg::CREG_RSV);
    end
  end

  // ==========================================================================
  // Cross-path stall
  // ==========================================================================
  // Registers written this cycle by anything but load data. A base update
  // counts, since it is an ordinary write in the first execute phase.
  always_comb begin
    wmask = '0;
    for (int s = 0; s < int'(dihc_pkg::NSLOT); s++) begin
      for (int l = 0; l < int'(dihc_pkg::LANE_LOAD); l++) begin
        if (wb[s][l].valid) begin
          wmask[{wb[s][l].side, wb[s][l].regn}] = 1'b1;
        end
      end
      if (base_upd[s].valid) begin
        wmask[{base_upd[s].side, base_upd[s].regn}] = 1'b1;
      end
    end
  end

  // A cross read always reaches into the file opposite the unit's own, so
  // the destination side fixes which register is compared.
  always_comb begin
    hazard = 1'b0;
    for (int s = 0; s < int'(dihc_pkg::NSLOT); s++) begin
      if (cand_v && cand[s].valid && cand[s].xsel &&
          wmask[{~side_of(s), cand[s].xreg}]) begin
        hazard = 1'b1;
      end
    end
  end

  // Park the packet for a cycle while the crossed register settles.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= ST_RUN;
      pk_ready <= 1'b1;
      stall <= 1'b0;
    end else begin
      state <= (cand_v && hazard) ? ST_PARK : ST_RUN;
      pk_ready <= !(cand_v && hazard);
      stall <= cand_v && hazard;
    end
  end

  // Parked copy of the stalled packet.
  always_ff @(posedge core_clk) begin
    for (int s = 0; s < int'(dihc_pkg::NSLOT); s++) begin
      if (srst) begin
        parked[s] <= '0;
      end else if (cand_v && hazard) begin
        parked[s] <= cand[s];
      end
    end
  end

  // ==========================================================================
  // Packet checks
  // ==========================================================================
  // These flag packets the scheduler should never build; the hardware
  // still issues them, so a flag is diagnostic only.
  always_comb begin
    next_error = '0;
    nmem = '0;
    for (int s = 0; s < int'(dihc_pkg::NSLOT); s++) begin
      if (cand[s].valid && cand[s].mem) begin
        nmem = nmem + 4'h1;
        if (cand[s].base_side != side_of(s)) begin
          next_error.addr_side = 1'b1;
        end
        if (cand[s].xsel) begin
          next_error.dmem_cross = 1'b1;
        end
      end
      for (int t = s + 1; t < int'(dihc_pkg::NSLOT); t++) begin
        if (cand[s].valid && cand[t].valid && cand[s].xsel &&
            cand[t].xsel && side_of(s) == side_of(t) &&
            cand[s].xreg != cand[t].xreg) begin
          next_error.xpath_conflict = 1'b1;
        end
        if (cand[s].valid && cand[t].valid && cand[s].mem &&
            cand[t].mem && cand[s].data_side == cand[t].data_side) begin
          next_error.ls_same_file = 1'b1;
        end
      end
    end
    for (int s = 0; s < int'(dihc_pkg::NSLOT); s++) begin
      if (cand[s].valid && cand[s].mem && cand[s].nonaligned &&
          nmem > 4'h1) begin
        next_error.nonaligned_mix = 1'b1;
      end
    end
  end

  // ==========================================================================
  // First execute phase
  // ==========================================================================
  // Results go to the destination file; loads and stores name theirs.
  always_comb begin
    for (int s = 0; s < int'(dihc_pkg::NSLOT); s++) begin
      cls[s] = cand[s].cls;
      ev[s].valid = pass[s] && writes(cand[s].cls);
      ev[s].side = cand[s].mem ? cand[s].data_side : side_of(s);
      ev[s].regn = cand[s].dst;
    end
  end

  // Issue outputs mark cycle i; annulled slots leave no trace except through bkpt_hit, cond_rsv, pk_error and cross-path stalls.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      exec_mask <= '0;
      bkpt_hit <= 1'b0;
      cond_rsv <= 1'b0;
      pk_error <= '0;
    end else begin
      exec_mask <= fire ? pass : '0;
      bkpt_hit <= fire && (|bk);
      cond_rsv <= fire && (|rs);
      pk_error <= fire ? next_error : '0;
    end
  end

  // Base updates and memory routing. The transfer resource follows the
  // data file while the address comes from the executing unit's own side.
  always_ff @(posedge core_clk) begin
    for (int s = 0; s < int'(dihc_pkg::NSLOT); s++) begin
      if (srst) begin
        base_upd[s] <= '0;
        mem_route[s] <= '0;
      end else begin
        base_upd[s].valid <= fire && pass[s] && cand[s].mem &&
          cand[s].base_upd;
        base_upd[s].side <= cand[s].base_side;
        base_upd[s].regn <= cand[s].base_reg;
        mem_route[s].valid <= fire && pass[s] && cand[s].mem;
        mem_route[s].xfer_res <= cand[s].data_side;
        mem_route[s].addr_file <= side_of(s);
      end
    end
  end

  // Branch effect travels a short shift register to land at i+5.
  always_comb begin
    br_now = 1'b0;
    for (int s = 0; s < int'(dihc_pkg::NSLOT); s++) begin
      if (pass[s] && cand[s].cls == dihc_pkg::CLS_BRANCH) begin
        br_now = fire;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      br_pipe <= '0;
      branch_take <= 1'b0;
    end else begin
      br_pipe <= {br_now, br_pipe[dihc_pkg::BR_TAKE-1:1]};
      branch_take <= br_pipe[0];
    end
  end

  // ==========================================================================
  // Result scheduling
  // ==========================================================================
  dihc_result_delay u_delay (
    .core_clk(core_clk),
    .srst(srst),
    .fire(fire),
    .ev_in(ev),
    .cls_in(cls),
    .wb(wb)
  );

  // ==========================================================================
  // Checks
  // ==========================================================================
  single_wb_a: assert property (
    @(posedge core_clk) disable iff (srst)
    fire && pass[0] && cand[0].cls == dihc_pkg::CLS_SINGLE
    |=> exec_mask[0] && wb[0][dihc_pkg::LANE_NOW].valid)
    else $error("single-cycle result not written at i");

  two_cycle_a: assert property (
    @(posedge core_clk) disable iff (srst)
    fire && pass[0] && cand[0].cls == dihc_pkg::CLS_TWO
    |=> ##1 wb[0][dihc_pkg::LANE_TWO].valid &&
        wb[0][dihc_pkg::LANE_TWO].regn == $past(cand[0].dst, 2))
    else $error("two-cycle result not written at i+1");

  four_cycle_a: assert property (
    @(posedge core_clk) disable iff (srst)
    fire && pass[0] && cand[0].cls == dihc_pkg::CLS_FOUR
    |=> ##3 wb[0][dihc_pkg::LANE_FOUR].valid)
    else $error("four-cycle result not written at i+3");

  load_data_a: assert property (
    @(posedge core_clk) disable iff (srst)
    fire && pass[3] && cand[3].cls == dihc_pkg::CLS_LOAD
    |=> ##4 wb[3][dihc_pkg::LANE_LOAD].valid)
    else $error("load data not written at i+4");

  branch_time_a: assert property (
    @(posedge core_clk) disable iff (srst)
    br_now |=> !branch_take [*5] ##1 branch_take)
    else $error("branch did not take effect at i+5");

  annul_slot_a: assert property (
    @(posedge core_clk) disable iff (srst)
    fire && cand[0].valid && !pass[0]
    |=> !exec_mask[0] && !wb[0][dihc_pkg::LANE_NOW].valid)
    else $error("annulled instruction had an effect");

  cross_stall_a: assert property (
    @(posedge core_clk) disable iff (srst)
    cand_v && hazard |=> stall && !pk_ready && exec_mask == '0)
    else $error("cross-path hazard did not stall");

  issue_rate_a: assert property (
    @(posedge core_clk) disable iff (srst)
    fire && state == ST_RUN |=> pk_ready && !stall)
    else $error("issue slot lost without a hazard");

endmodule // dihc_issue_control

/* File: common/dihc_pkg.sv */
// Types and constants shared by the issue and hazard control files.
// Assumes one core clock and a synchronous, active-high reset.
package dihc_pkg;

  // ==========================================================================
  // Packet shape
  // ==========================================================================
  // Slot index is {side, unit}: slots 0..3 are side A, 4..7 are side B.
  localparam int unsigned NSLOT = 8;
  localparam int unsigned SLOTS_PER_SIDE = 4;
  localparam int unsigned NCOND = 6;
  localparam int unsigned UNIT_D = 3;
  localparam logic SIDE_A = 1'b0;
  localparam logic SIDE_B = 1'b1;

  // ==========================================================================
  // Opcode condition field
  // ==========================================================================
  localparam int unsigned CREG_HI = 31;
  localparam int unsigned ZBIT = 28;
  localparam logic [2:0] CREG_NONE = 3'h0;
  localparam logic [2:0] CREG_B0 = 3'h1;
  localparam logic [2:0] CREG_B1 = 3'h2;
  localparam logic [2:0] CREG_B2 = 3'h3;
  localparam logic [2:0] CREG_A1 = 3'h4;
  localparam logic [2:0] CREG_A2 = 3'h5;
  localparam logic [2:0] CREG_A0 = 3'h6;
  localparam logic [2:0] CREG_RSV = 3'h7;
  // Bit positions in the condition-register nonzero vector.
  localparam int unsigned IDX_A0 = 0;
  localparam int unsigned IDX_A1 = 1;
  localparam int unsigned IDX_A2 = 2;
  localparam int unsigned IDX_B0 = 3;
  localparam int unsigned IDX_B1 = 4;
  localparam int unsigned IDX_B2 = 5;

  // ==========================================================================
  // Latency schedule, in cycles after the first execute phase
  // ==========================================================================
  localparam int unsigned WR_SINGLE = 0;
  localparam int unsigned WR_TWO = 1;
  localparam int unsigned WR_FOUR = 3;
  localparam int unsigned WR_LOAD = 4;
  localparam int unsigned BR_TAKE = 5;
  localparam int unsigned NLANE = 4;
  localparam int unsigned LANE_NOW = 0;
  localparam int unsigned LANE_TWO = 1;
  localparam int unsigned LANE_FOUR = 2;
  localparam int unsigned LANE_LOAD = 3;
  localparam int unsigned LANE_DEPTH [NLANE] =
    '{WR_SINGLE, WR_TWO, WR_FOUR, WR_LOAD};

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    CLS_NOP = 3'h0,
    CLS_STORE = 3'h1,
    CLS_SINGLE = 3'h2,
    CLS_TWO = 3'h3,
    CLS_MPY = 3'h4,
    CLS_FOUR = 3'h5,
    CLS_LOAD = 3'h6,
    CLS_BRANCH = 3'h7
  } dihc_class_type;

  typedef struct packed {
    logic valid;
    logic [31:0] opword;
    dihc_class_type cls;
    logic xsel;
    logic [4:0] xreg;
    logic [4:0] dst;
    logic mem;
    logic nonaligned;
    logic base_upd;
    logic base_side;
    logic [4:0] base_reg;
    logic data_side;
  } dihc_slot_type;

  typedef struct packed {
    logic valid;
    logic side;
    logic [4:0] regn;
  } dihc_event_type;

  typedef struct packed {
    logic valid;
    logic xfer_res;
    logic addr_file;
  } dihc_route_type;

  typedef struct packed {
    logic xpath_conflict;
    logic ls_same_file;
    logic addr_side;
    logic nonaligned_mix;
    logic dmem_cross;
  } dihc_error_type;

endpackage

/* File: hdl/dihc_result_delay.sv */
// Delay lines that hold each slot's pending register writes until due.
// Assumes events are offered only in the cycle a packet enters execute.
`timescale 1ns/1ns
module dihc_result_delay (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Events offered as a packet enters its first execute phase
  input wire logic fire,
  input wire dihc_pkg::dihc_event_type ev_in [dihc_pkg::NSLOT],
  input wire dihc_pkg::dihc_class_type cls_in [dihc_pkg::NSLOT],
  // Writes due in the current cycle, one lane per latency
  output dihc_pkg::dihc_event_type wb [dihc_pkg::NSLOT][dihc_pkg::NLANE]
);

  // ==========================================================================
  // Lane selection
  // ==========================================================================
  // Multiplies share the two-cycle lane since both write one cycle late.
  function automatic logic lane_hit(input dihc_pkg::dihc_class_type c,
                                    input int unsigned l);
    unique case (c)
      dihc_pkg::CLS_SINGLE: lane_hit = (l == dihc_pkg::LANE_NOW);
      dihc_pkg::CLS_TWO: lane_hit = (l == dihc_pkg::LANE_TWO);
      dihc_pkg::CLS_MPY: lane_hit = (l == dihc_pkg::LANE_TWO);
      dihc_pkg::CLS_FOUR: lane_hit = (l == dihc_pkg::LANE_FOUR);
      dihc_pkg::CLS_LOAD: lane_hit = (l == dihc_pkg::LANE_LOAD);
      dihc_pkg::CLS_NOP,
      dihc_pkg::CLS_STORE,
      dihc_pkg::CLS_BRANCH: lane_hit = 1'b0;
    endcase
  endfunction

  // ==========================================================================
  // Delay lines
  // ==========================================================================
  // Separate lanes keep two classes from colliding in one slot's output.
  for (genvar s = 0; s < dihc_pkg::NSLOT; s++) begin : g_slot
    for (genvar l = 0; l < dihc_pkg::NLANE; l++) begin : g_lane
      localparam int unsigned DEPTH = dihc_pkg::LANE_DEPTH[l];
      dihc_pkg::dihc_event_type pipe [dihc_pkg::WR_LOAD+1];
      logic hit;

      assign hit = fire && ev_in[s].valid && lane_hit(cls_in[s], l);

      // An event enters at its depth and steps down once per cycle.
      always_ff @(posedge core_clk) begin
        for (int k = 0; k <= int'(dihc_pkg::WR_LOAD); k++) begin
          if (srst) begin
            pipe[k] <= '0;
          end else if (k == int'(DEPTH)) begin
            pipe[k] <= hit ? ev_in[s] : '0;
          end else if (k < int'(dihc_pkg::WR_LOAD)) begin
            pipe[k] <= pipe[k+1];
          end else begin
            pipe[k] <= '0;
          end
        end
      end

      assign wb[s][l] = pipe[0];
    end
  end

endmodule // dihc_result_delay

/* File: verif/dihc_issue_control_test.sv */
// Self-checking bench for the issue and hazard control block.
// Assumes the bench drives every port itself, at the falling clock edge.
`timescale 1ns/1ns
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
  error_cnt++; $display("wrong value at %0t: got %h expected %h", \
  $time, got, exp); end end
module dihc_issue_control_test;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic core_clk;
  logic srst;
  logic pk_valid;
  dihc_pkg::dihc_slot_type pk [dihc_pkg::NSLOT];
  logic [5:0] cond_nonzero;
  logic pk_ready, stall, bkpt_hit, cond_rsv, branch_take;
  logic [7:0] exec_mask;
  dihc_pkg::dihc_event_type base_upd [dihc_pkg::NSLOT];
  dihc_pkg::dihc_route_type mem_route [dihc_pkg::NSLOT];
  dihc_pkg::dihc_error_type pk_error;
  dihc_pkg::dihc_event_type wb [dihc_pkg::NSLOT][dihc_pkg::NLANE];
  int error_cnt;
  int num_checks;
  // Condition selector to nonzero-vector bit; entry 0 is unused.
  localparam int IDX [7] = '{0, 3, 4, 5, 1, 2, 0};

  dihc_issue_control u_dut (.core_clk(core_clk), .srst(srst),
    .pk_valid(pk_valid), .pk(pk), .cond_nonzero(cond_nonzero),
    .pk_ready(pk_ready), .stall(stall), .exec_mask(exec_mask),
    .base_upd(base_upd), .mem_route(mem_route), .bkpt_hit(bkpt_hit),
    .cond_rsv(cond_rsv), .pk_error(pk_error), .branch_take(branch_take),
    .wb(wb));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Clock at 125 MHz.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  function automatic dihc_pkg::dihc_slot_type mk(
    dihc_pkg::dihc_class_type c, logic [4:0] d);
    dihc_pkg::dihc_slot_type s;
    s = '0;
    s.valid = 1'b1;
    s.cls = c;
    s.dst = d;
    return s;
  endfunction

  // Empties every slot so each scenario starts from a blank packet.
  task automatic clr();
    foreach (pk[s]) pk[s] = '0;
  endtask

  // Offers the packet across one rising edge; valid stays up on return.
  task automatic fire();
    pk_valid = 1'b1;
    @(negedge core_clk);
  endtask

  // Drops the offer and lets n cycles pass so no write is still pending.
  task automatic idle(int n);
    pk_valid = 1'b0;
    repeat (n) @(negedge core_clk);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Every class but nop and store in one packet; each result lane must pulse on its own cycle.
  task automatic t_latency();
    clr();
    pk[0] = mk(dihc_pkg::CLS_SINGLE, 5'h01);
    pk[1] = mk(dihc_pkg::CLS_TWO, 5'h02);
    pk[2] = mk(dihc_pkg::CLS_FOUR, 5'h03);
    pk[3] = mk(dihc_pkg::CLS_LOAD, 5'h04);
    pk[3].mem = 1'b1;
    pk[3].base_upd = 1'b1;
    pk[3].base_reg = 5'h06;
    pk[4] = mk(dihc_pkg::CLS_BRANCH, 5'h00);
    pk[5] = mk(dihc_pkg::CLS_MPY, 5'h07);
    fire();
    idle(0);
    `CHK(exec_mask, 8'h3f)
    `CHK(base_upd[3], 7'h46)
    for (int k = 1; k <= 6; k++) begin
      `CHK({wb[0][0].valid, wb[1][1].valid, wb[5][1].valid, wb[2][2].valid,
        wb[3][3].valid, branch_take}, {k == 1, k == 2, k == 2, k == 4,
        k == 5, k == 6})
      if (k == 4) `CHK(wb[2][2].regn, 5'h03)
      @(negedge core_clk);
    end
  endtask

  // The same unit takes a new four-cycle instruction on two cycles running.
  task automatic t_b2b();
    clr();
    pk[2] = mk(dihc_pkg::CLS_FOUR, 5'h08);
    fire();
    `CHK(exec_mask, 8'h04)
    pk[2].dst = 5'h09;
    fire();
    idle(0);
    `CHK({exec_mask, pk_ready}, 9'h009)
    @(negedge core_clk);
    @(negedge core_clk);
    `CHK(wb[2][2].regn, 5'h08)
    @(negedge core_clk);
    `CHK(wb[2][2].regn, 5'h09)
  endtask

  // Every condition-register selector and zero-test pair, with the other registers opposed.
  task automatic t_pred();
    for (int c = 1; c <= 6; c++) begin
      for (int z = 0; z <= 1; z++) begin
        for (int nz = 0; nz <= 1; nz++) begin
          clr();
          pk[0] = mk(dihc_pkg::CLS_SINGLE, 5'h0a);
          pk[0].opword[31:28] = {3'(c), 1'(z)};
          cond_nonzero = 6'(1 << IDX[c]);
          if (nz == 0) cond_nonzero = ~cond_nonzero;
          fire();
          `CHK({exec_mask[0], wb[0][0].valid}, {2{1'(nz ^ z)}})
        end
      end
    end
    foreach (pk[s]) pk[s].opword[31:28] = 4'h1;
    fire();
    `CHK({bkpt_hit, cond_rsv, exec_mask}, 10'h200)
    for (int r = 14; r <= 15; r++) begin
      pk[0].opword[31:28] = 4'(r);
      fire();
      `CHK({bkpt_hit, cond_rsv, exec_mask}, 10'h100)
    end
    idle(2);
  endtask

  // Cross read of an ALU result stalls once; of loaded data it does not.
  task automatic t_stall();
    clr();
    pk[0] = mk(dihc_pkg::CLS_SINGLE, 5'h01);
    fire();
    clr();
    pk[4] = mk(dihc_pkg::CLS_SINGLE, 5'h02);
    pk[4].xsel = 1'b1;
    pk[4].xreg = 5'h01;
    @(negedge core_clk);
    `CHK({stall, pk_ready, exec_mask}, 10'h200)
    @(negedge core_clk);
    `CHK({stall, pk_ready, exec_mask}, 10'h110)
    idle(3);
    clr();
    pk[3] = mk(dihc_pkg::CLS_LOAD, 5'h05);
    pk[3].mem = 1'b1;
    fire();
    idle(4);
    clr();
    pk[4] = mk(dihc_pkg::CLS_SINGLE, 5'h02);
    pk[4].xsel = 1'b1;
    pk[4].xreg = 5'h05;
    fire();
    idle(0);
    `CHK({stall, pk_ready, exec_mask}, 10'h110)
    idle(3);
  endtask

  // Packet checks: shared cross path, data files, address side, non-aligned.
  task automatic t_err();
    clr();
    pk[4] = mk(dihc_pkg::CLS_SINGLE, 5'h02);
    pk[4].xsel = 1'b1;
    pk[4].xreg = 5'h0b;
    pk[5] = pk[4];
    fire();
    `CHK(pk_error, 5'h00)
    pk[5].xreg = 5'h0c;
    fire();
    `CHK(pk_error, 5'h10)
    clr();
    pk[3] = mk(dihc_pkg::CLS_LOAD, 5'h0d);
    pk[3].mem = 1'b1;
    pk[7] = pk[3];
    pk[7].base_side = 1'b1;
    fire();
    `CHK(pk_error, 5'h08)
    pk[7] = mk(dihc_pkg::CLS_SINGLE, 5'h0e);
    pk[3].base_side = 1'b1;
    pk[3].data_side = 1'b1;
    fire();
    `CHK(pk_error, 5'h04)
    pk[3].base_side = 1'b0;
    pk[3].nonaligned = 1'b1;
    fire();
    `CHK(pk_error, 5'h00)
    `CHK(mem_route[3], 3'h6)
    pk[7] = mk(dihc_pkg::CLS_STORE, 5'h00);
    pk[7].mem = 1'b1;
    pk[7].base_side = 1'b1;
    fire();
    idle(0);
    `CHK(pk_error, 5'h02)
    pk[3].nonaligned = 1'b0;
    pk[7].xsel = 1'b1;
    fire();
    idle(0);
    `CHK(pk_error, 5'h01)
    idle(6);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    error_cnt = 0;
    num_checks = 0;
    srst = 1'b1;
    pk_valid = 1'b0;
    cond_nonzero = 6'h00;
    clr();
    repeat (8) @(negedge core_clk);
    srst = 1'b0;
    `CHK({pk_ready, exec_mask}, 9'h100)
    t_latency();
    t_b2b();
    t_pred();
    t_stall();
    t_err();
    results();
  end

  // A hang is cut short here and counts as a mismatch.
  initial begin
    #400000;
    error_cnt++;
    results();
  end
endmodule // dihc_issue_control_test
